// >>> core/rsf_pkg.sv
// Shared constants for the receive path status and flag block
package rsf_pkg;
  // ----------------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------------
  localparam logic [5:0]  OFF_CTRL     = 6'h00;
  localparam logic [5:0]  OFF_MAXLEN   = 6'h04;
  localparam logic [5:0]  OFF_STATUS   = 6'h08;
  localparam logic [5:0]  OFF_LANES    = 6'h0C;
  // ----------------------------------------------------------------------
  // Control fields
  // ----------------------------------------------------------------------
  localparam int          CTRL_PRE_EN  = 0;
  localparam int          CTRL_TPG     = 1;
  localparam int          CTRL_LFI     = 2;
  localparam logic [2:0]  CTRL_RST     = 3'h4;
  localparam int          MAXLEN_W     = 15;
  localparam logic [14:0] MAXLEN_RST   = 15'h2580;
  // ----------------------------------------------------------------------
  // Status fields
  // ----------------------------------------------------------------------
  localparam int          ST_ALIGN_ERR = 0;
  localparam int          ST_REM_FLT   = 1;
  localparam int          ST_INT_LF    = 2;
  localparam int          ST_RX_LF     = 3;
  localparam int          ST_LF        = 4;
  localparam int          ST_HI_BER    = 5;
  localparam int          ST_ALL_SEEN  = 6;
  localparam int          LANES_DEMUX  = 16;
  // ----------------------------------------------------------------------
  // Fault sequence detection and misalignment metaframe length
  // ----------------------------------------------------------------------
  localparam logic [2:0]  LF_TRIG      = 3'h4;
  localparam logic [7:0]  LF_WINDOW    = 8'h80;
  localparam int          METAFRAME    = 16384;
endpackage : rsf_pkg

// >>> core/rsf_rx_status.sv
// Receive path status, fault and error indicator logic with register port
//
// Summary of operation
// - Alignment error level while lanes not aligned
// - Misalignment pulse one metaframe after bad marker
// - No misalignment before markers seen on all lanes
// - Malformed marker words go to per-lane error
// - Remote fault status follows detected condition
// - Per physical lane PCS lane number output
// - Demux-found bit per correctly demuxed PCS lane
// - Bad FCS increment excludes stomped FCS
// - Stomped means FCS equals inverted expected value
// - Stomped FCS increment per packet
// - Truncate oversize packet, pulse truncation once
// - Internal fault on test pattern, misalign, high BER
// - Received fault from link fault sequence machine
// - Per lane BIP8 error one-cycle pulse
// - High error rate flag follows BER monitor
// - Preamble shown on bus when enabled
// - Preamble valid on packet first cycle
// - Pulses may repeat on consecutive cycles
// - Local fault is internal or received fault
// - Synced only after word sync and marker
//
// Decided for this implementation: the Avalon-MM interface to the registers and the register offsets.
`timescale 1ns/1ps

module rsf_rx_status #(
  parameter int L          = 4,
  parameter int ID_W       = (L > 1) ? $clog2(L) : 1,
  parameter int MF_CYCLES  = rsf_pkg::METAFRAME
) (
  input  wire logic                 mclk_i,
  input  wire logic                 rst_n_i,
  // Avalon-MM slave
  input  wire logic [5:0]           avs_address_i,
  input  wire logic                 avs_read_i,
  input  wire logic                 avs_write_i,
  input  wire logic [31:0]          avs_writedata_i,
  output logic      [31:0]          avs_readdata_o,
  output logic                      avs_waitrequest_o,
  // Lane synchronisation inputs
  input  wire logic [L-1:0]         lane_word_sync_i,
  input  wire logic [L-1:0]         lane_marker_ok_i,
  input  wire logic [L-1:0]         lane_marker_wrong_i,
  input  wire logic [L-1:0]         lane_marker_malformed_i,
  input  wire logic [L*ID_W-1:0]    lane_marker_id_i,
  input  wire logic [L-1:0]         lane_bip_bad_i,
  input  wire logic                 lanes_aligned_i,
  input  wire logic                 ber_high_i,
  input  wire logic                 remote_fault_det_i,
  input  wire logic                 lf_seq_i,
  input  wire logic                 column_i,
  // Packet stream
  input  wire logic                 pkt_valid_i,
  input  wire logic                 pkt_sop_i,
  input  wire logic                 pkt_eop_i,
  input  wire logic [7:0]           pkt_bytes_i,
  input  wire logic [55:0]          pkt_preamble_i,
  input  wire logic [31:0]          pkt_fcs_i,
  input  wire logic [31:0]          pkt_fcs_calc_i,
  // Status outputs
  output logic                      aligned_err_o,
  output logic                      misaligned_o,
  output logic [L-1:0]              marker_word_error_o,
  output logic                      remote_fault_o,
  output logic [L*ID_W-1:0]         lane_id_per_physical_lane_o,
  output logic [L-1:0]              lane_synced_o,
  output logic [L-1:0]              lane_demux_found_o,
  output logic [1:0]                bad_fcs_o,
  output logic [1:0]                stomped_fcs_o,
  output logic                      truncated_o,
  output logic                      pkt_drop_o,
  output logic                      internal_local_fault_o,
  output logic                      received_local_fault_o,
  output logic                      local_fault_o,
  output logic [L-1:0]              bip_err_o,
  output logic                      high_error_rate_flag_o,
  output logic [55:0]               preamble_o,
  output logic                      preamble_valid_o
);

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  typedef enum logic {RSF_LF_OK, RSF_LF_FAULT} rsf_lf_st_t;

  typedef struct packed {
    logic [31:0]          rdata;
    logic                 wait_n;
    logic                 wreq;
    logic [2:0]           ctrl;
    logic [14:0]          maxlen;
    logic                 align_err;
    logic                 misal;
    logic [L-1:0]         mf_err;
    logic                 rem_flt;
    logic [L*ID_W-1:0]    lane_id;
    logic [L-1:0]         mk_seen;
    logic [L-1:0]         synced;
    logic [L-1:0]         demux;
    logic [L-1:0]         all_seen_lane;
    logic                 mf_run;
    logic [31:0]          mf_cnt;
    logic [1:0]           bad_fcs;
    logic [1:0]           stomp_fcs;
    logic [15:0]          pkt_len;
    logic                 in_pkt;
    logic                 trunc_done;
    logic                 trunc;
    logic                 drop;
    logic                 int_lf;
    rsf_lf_st_t           lf_st;
    logic                 rx_lf;
    logic [2:0]           lf_cnt;
    logic [7:0]           col_cnt;
    logic                 lf;
    logic [L-1:0]         bip;
    logic                 hi_ber;
    logic [55:0]          pre;
    logic                 pre_vld;
  } rsf_state_t;

  rsf_state_t s_r;
  rsf_state_t s_nxt;

  // Misalignment wait ends on the last cycle of one metaframe
  localparam logic [31:0] MF_LAST = 32'(MF_CYCLES - 1);

  logic        req;
  logic [15:0] len_sum;
  logic        all_seen;
  logic [31:0] status_w;
  logic [31:0] lanes_w;

  assign req      = avs_read_i | avs_write_i;
  assign all_seen = &s_r.mk_seen;
  assign len_sum  = s_r.pkt_len + {8'h00, pkt_bytes_i};

  // ----------------------------------------------------------------------
  // Register read views
  // ----------------------------------------------------------------------
  always_comb begin
    status_w = 32'h0000_0000;
    status_w[rsf_pkg::ST_ALIGN_ERR] = s_r.align_err;
    status_w[rsf_pkg::ST_REM_FLT]   = s_r.rem_flt;
    status_w[rsf_pkg::ST_INT_LF]    = s_r.int_lf;
    status_w[rsf_pkg::ST_RX_LF]     = (s_r.lf_st == RSF_LF_FAULT);
    status_w[rsf_pkg::ST_LF]        = s_r.lf;
    status_w[rsf_pkg::ST_HI_BER]    = s_r.hi_ber;
    status_w[rsf_pkg::ST_ALL_SEEN]  = all_seen;
    lanes_w = 32'h0000_0000;
    lanes_w[L-1:0] = s_r.synced;
    lanes_w[rsf_pkg::LANES_DEMUX +: L] = s_r.demux;
  end

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb begin
    s_nxt = s_r;

    // ----------------------------------------
    // Register port
    // ----------------------------------------
    // A request seen with wait high drops wait for one cycle; the
    // write lands on the edge that samples wait low.
    if (req && !s_r.wait_n) begin
      s_nxt.wait_n = 1'b1;
      s_nxt.rdata  = 32'h0000_0000;
      if (avs_read_i) begin
        case (avs_address_i)
          rsf_pkg::OFF_CTRL:   s_nxt.rdata = {29'h0, s_r.ctrl};
          rsf_pkg::OFF_MAXLEN: s_nxt.rdata = {17'h0, s_r.maxlen};
          rsf_pkg::OFF_STATUS: s_nxt.rdata = status_w;
          rsf_pkg::OFF_LANES:  s_nxt.rdata = lanes_w;
          default:             s_nxt.rdata = 32'h0000_0000;
        endcase
      end
    end else if (req && s_r.wait_n) begin
      s_nxt.wait_n = 1'b0;
      if (avs_write_i) begin
        case (avs_address_i)
          rsf_pkg::OFF_CTRL:   s_nxt.ctrl   = avs_writedata_i[2:0];
          rsf_pkg::OFF_MAXLEN: s_nxt.maxlen =
                                 avs_writedata_i[rsf_pkg::MAXLEN_W-1:0];
          default: ;
        endcase
      end
    end else begin
      s_nxt.wait_n = 1'b0;
    end
    // A flop of its own, so no gate sits between register and pin
    s_nxt.wreq = ~s_nxt.wait_n;

    // ----------------------------------------
    // Level and pulse copies
    // ----------------------------------------
    s_nxt.align_err = ~lanes_aligned_i;
    s_nxt.rem_flt   = remote_fault_det_i;
    s_nxt.hi_ber    = ber_high_i;
    s_nxt.mf_err    = lane_marker_malformed_i;
    s_nxt.bip       = lane_bip_bad_i;

    // ----------------------------------------
    // Lane tracking
    // ----------------------------------------
    // A marker only counts while word sync holds
    for (int i = 0; i < L; i++) begin
      if (!lane_word_sync_i[i]) begin
        s_nxt.mk_seen[i] = 1'b0;
      end else if (lane_marker_ok_i[i]) begin
        s_nxt.mk_seen[i] = 1'b1;
        s_nxt.lane_id[i*ID_W +: ID_W] =
          lane_marker_id_i[i*ID_W +: ID_W];
      end
      s_nxt.synced[i] = lane_word_sync_i[i] & s_nxt.mk_seen[i];
    end

    // ----------------------------------------
    // Demux map
    // ----------------------------------------
    // A PCS lane is found once some synced lane carries its id
    for (int p = 0; p < L; p++) begin
      s_nxt.demux[p] = 1'b0;
      for (int i = 0; i < L; i++) begin
        if (s_nxt.synced[i] &&
            (s_nxt.lane_id[i*ID_W +: ID_W] == ID_W'(p))) begin
          s_nxt.demux[p] = 1'b1;
        end
      end
    end

    // ----------------------------------------
    // Misalignment
    // ----------------------------------------
    // Armed only once every lane has shown a good
    // marker. Later errors during the wait fold into one pulse.
    s_nxt.misal = 1'b0;
    if (s_r.mf_run) begin
      if (s_r.mf_cnt == MF_LAST) begin
        s_nxt.mf_run = 1'b0;
        s_nxt.mf_cnt = 32'h0000_0000;
        s_nxt.misal  = 1'b1;
      end else begin
        s_nxt.mf_cnt = s_r.mf_cnt + 32'h0000_0001;
      end
    end else if (all_seen && (|lane_marker_wrong_i)) begin
      s_nxt.mf_run = 1'b1;
      s_nxt.mf_cnt = 32'h0000_0000;
    end

    // ----------------------------------------
    // Packet checks
    // ----------------------------------------
    // One result per cycle, back to back allowed
    s_nxt.bad_fcs   = 2'h0;
    s_nxt.stomp_fcs = 2'h0;
    s_nxt.trunc     = 1'b0;
    s_nxt.pre_vld   = 1'b0;
    if (pkt_valid_i) begin
      if (pkt_sop_i) begin
        s_nxt.pkt_len    = {8'h00, pkt_bytes_i};
        s_nxt.trunc_done = 1'b0;
        s_nxt.in_pkt     = 1'b1;
        s_nxt.pre_vld    = 1'b1;
        if (s_r.ctrl[rsf_pkg::CTRL_PRE_EN]) begin
          s_nxt.pre = pkt_preamble_i;
        end
      end else if (s_r.in_pkt) begin
        s_nxt.pkt_len = len_sum;
      end
      if ((s_nxt.pkt_len > {1'b0, s_r.maxlen}) &&
          !s_nxt.trunc_done) begin
        s_nxt.trunc      = 1'b1;
        s_nxt.trunc_done = 1'b1;
      end
      if (pkt_eop_i) begin
        s_nxt.in_pkt = 1'b0;
        if (pkt_fcs_i == ~pkt_fcs_calc_i) begin
          s_nxt.stomp_fcs = 2'h1;
        end else if (pkt_fcs_i != pkt_fcs_calc_i) begin
          s_nxt.bad_fcs = 2'h1;
        end
      end
    end
    // Data beyond the limit is dropped for the rest of the packet, except the end-of-packet beat
    s_nxt.drop = pkt_valid_i & s_nxt.trunc_done & s_nxt.in_pkt;

    // ----------------------------------------
    // Local fault
    // ----------------------------------------
    s_nxt.int_lf = s_r.ctrl[rsf_pkg::CTRL_TPG] | ~lanes_aligned_i
                   | ber_high_i;

    // ----------------------------------------
    // Received fault sequences
    // ----------------------------------------
    // LF_TRIG sequences with no gap of a full
    // window enter fault; a full clean window leaves it.
    if (lf_seq_i && s_r.ctrl[rsf_pkg::CTRL_LFI]) begin
      s_nxt.col_cnt = 8'h00;
      if (s_r.lf_cnt != rsf_pkg::LF_TRIG) begin
        s_nxt.lf_cnt = s_r.lf_cnt + 3'h1;
      end
    end else if (column_i) begin
      if (s_r.col_cnt == rsf_pkg::LF_WINDOW - 8'h01) begin
        s_nxt.col_cnt = 8'h00;
        s_nxt.lf_cnt  = 3'h0;
      end else begin
        s_nxt.col_cnt = s_r.col_cnt + 8'h01;
      end
    end

    // Fault state follows the running sequence count
    case (s_r.lf_st)
      RSF_LF_OK: begin
        if (s_nxt.lf_cnt == rsf_pkg::LF_TRIG) begin
          s_nxt.lf_st = RSF_LF_FAULT;
        end
      end
      RSF_LF_FAULT: begin
        if (s_nxt.lf_cnt == 3'h0) begin
          s_nxt.lf_st = RSF_LF_OK;
        end
      end
      default: s_nxt.lf_st = RSF_LF_OK;
    endcase
    // Registered copy so the output pin carries no decode
    s_nxt.rx_lf = (s_nxt.lf_st == RSF_LF_FAULT);
    s_nxt.lf = s_nxt.int_lf | s_nxt.rx_lf;
  end

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_r        <= '0;
      s_r.ctrl   <= rsf_pkg::CTRL_RST;
      s_r.maxlen <= rsf_pkg::MAXLEN_RST;
      s_r.lf_st  <= RSF_LF_OK;
      // Waitrequest stands high so no request is taken in reset
      s_r.wreq   <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs, all straight from the state register
  // ----------------------------------------------------------------------
  assign avs_readdata_o              = s_r.rdata;
  assign avs_waitrequest_o           = s_r.wreq;
  assign aligned_err_o               = s_r.align_err;
  assign misaligned_o                = s_r.misal;
  assign marker_word_error_o         = s_r.mf_err;
  assign remote_fault_o              = s_r.rem_flt;
  assign lane_id_per_physical_lane_o = s_r.lane_id;
  assign lane_synced_o               = s_r.synced;
  assign lane_demux_found_o          = s_r.demux;
  assign bad_fcs_o                   = s_r.bad_fcs;
  assign stomped_fcs_o               = s_r.stomp_fcs;
  assign truncated_o                 = s_r.trunc;
  assign pkt_drop_o                  = s_r.drop;
  assign internal_local_fault_o      = s_r.int_lf;
  assign received_local_fault_o      = s_r.rx_lf;
  assign local_fault_o               = s_r.lf;
  assign bip_err_o                   = s_r.bip;
  assign high_error_rate_flag_o      = s_r.hi_ber;
  assign preamble_o                  = s_r.pre;
  assign preamble_valid_o            = s_r.pre_vld;

endmodule // rsf_rx_status

// >>> sim/rsf_rx_status_monitor.sv
// Assertion checker for the receive status block
`timescale 1ns/1ps
module rsf_rx_status_monitor #(
  parameter int L = 4
) (
  input wire logic         mclk_i,
  input wire logic         rst_n_i,
  input wire logic         lanes_aligned_i,
  input wire logic         ber_high_i,
  input wire logic [L-1:0] lane_marker_malformed_i,
  input wire logic [L-1:0] lane_bip_bad_i,
  input wire logic         pkt_valid_i,
  input wire logic         pkt_sop_i,
  input wire logic         pkt_eop_i,
  input wire logic [31:0]  pkt_fcs_i,
  input wire logic [31:0]  pkt_fcs_calc_i,
  input wire logic         aligned_err_o,
  input wire logic [L-1:0] marker_word_error_o,
  input wire logic [L-1:0] bip_err_o,
  input wire logic         internal_local_fault_o,
  input wire logic         received_local_fault_o,
  input wire logic         local_fault_o,
  input wire logic [1:0]   bad_fcs_o,
  input wire logic [1:0]   stomped_fcs_o,
  input wire logic         preamble_valid_o,
  input wire logic         truncated_o,
  input wire logic         misaligned_o
);
  // ----------
  // Properties
  // ----------
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);
  // Past guard: the cycle after reset still holds reset values
  wire logic eop   = pkt_valid_i && pkt_eop_i;
  wire logic stomp = pkt_fcs_i == ~pkt_fcs_calc_i;
  property p_align;
    $past(rst_n_i) |-> aligned_err_o == !$past(lanes_aligned_i);
  endproperty
  a_align: assert property (p_align) else $error("align level wrong");
  property p_mword;
    $past(rst_n_i) |-> marker_word_error_o == $past(lane_marker_malformed_i);
  endproperty
  a_mword: assert property (p_mword) else $error("marker pulse wrong");
  property p_bip;
    $past(rst_n_i) |-> bip_err_o == $past(lane_bip_bad_i);
  endproperty
  a_bip: assert property (p_bip) else $error("parity pulse wrong");
  property p_lf;
    local_fault_o == (internal_local_fault_o || received_local_fault_o);
  endproperty
  a_lf: assert property (p_lf) else $error("fault level wrong");
  property p_ilf;
    (ber_high_i || !lanes_aligned_i) |=> internal_local_fault_o;
  endproperty
  a_ilf: assert property (p_ilf) else $error("internal fault low");
  property p_stomp;
    eop && stomp |=> stomped_fcs_o == 2'h1 && bad_fcs_o == 2'h0;
  endproperty
  a_stomp: assert property (p_stomp) else $error("stomp wrong");
  property p_bad;
    eop && !stomp && pkt_fcs_i != pkt_fcs_calc_i
      |=> bad_fcs_o == 2'h1 && stomped_fcs_o == 2'h0;
  endproperty
  a_bad: assert property (p_bad) else $error("bad check wrong");
  property p_pre;
    pkt_valid_i && pkt_sop_i |=> preamble_valid_o;
  endproperty
  a_pre: assert property (p_pre) else $error("preamble late");
  c_stomp: cover property (stomped_fcs_o == 2'h1);
  c_trunc: cover property (truncated_o);
  c_mis: cover property (misaligned_o);
endmodule // rsf_rx_status_monitor

bind rsf_rx_status rsf_rx_status_monitor #(.L(L)) mon_u (
  .mclk_i(mclk_i), .rst_n_i(rst_n_i), .lanes_aligned_i(lanes_aligned_i),
  .ber_high_i(ber_high_i), .lane_marker_malformed_i(lane_marker_malformed_i),
  .lane_bip_bad_i(lane_bip_bad_i), .pkt_valid_i(pkt_valid_i),
  .pkt_sop_i(pkt_sop_i), .pkt_eop_i(pkt_eop_i), .pkt_fcs_i(pkt_fcs_i),
  .pkt_fcs_calc_i(pkt_fcs_calc_i), .aligned_err_o(aligned_err_o),
  .marker_word_error_o(marker_word_error_o), .bip_err_o(bip_err_o),
  .internal_local_fault_o(internal_local_fault_o),
  .received_local_fault_o(received_local_fault_o),
  .local_fault_o(local_fault_o), .bad_fcs_o(bad_fcs_o),
  .stomped_fcs_o(stomped_fcs_o), .preamble_valid_o(preamble_valid_o),
  .truncated_o(truncated_o), .misaligned_o(misaligned_o));

// >>> sim/rsf_user_model.sv
// User-side model that tallies status increment pulses
`timescale 1ns/1ps
module rsf_user_model #(
  parameter int L = 4
) (
  input  wire logic         mclk_i,
  input  wire logic [1:0]   bad_fcs_i,
  input  wire logic [1:0]   stomped_fcs_i,
  input  wire logic         truncated_i,
  input  wire logic         misaligned_i,
  input  wire logic [L-1:0] bip_err_i,
  output int                n_bad_o,
  output int                n_stomp_o,
  output int                n_trunc_o,
  output int                n_mis_o,
  output int                n_bip_o
);
  initial begin
    {n_bad_o, n_stomp_o, n_trunc_o, n_mis_o, n_bip_o} = '0;
  end
  // Every cycle a pulse stands is a new event, so no edge detect
  always @(posedge mclk_i) begin
    n_bad_o <= n_bad_o + int'(bad_fcs_i);
    n_stomp_o <= n_stomp_o + int'(stomped_fcs_i);
    n_trunc_o <= n_trunc_o + int'(truncated_i);
    n_mis_o <= n_mis_o + int'(misaligned_i);
    n_bip_o <= n_bip_o + $countones(bip_err_i);
  end
endmodule // rsf_user_model

// >>> sim/rx_path_status_flags_test.sv
// Self-checking bench for the receive status block
`timescale 1ns/1ps
module rx_path_status_flags_test;
  localparam int L = 4;
  localparam int MF = 8;
  logic mclk_i = 1'b0, rst_n_i = 1'b0, avs_read_i = 1'b0, avs_write_i = 1'b0;
  logic [5:0] avs_address_i = 6'h00;
  logic [31:0] avs_writedata_i = 32'h0, avs_readdata_o, rd;
  logic avs_waitrequest_o, lanes_aligned_i = 1'b1, ber_high_i = 1'b0;
  logic [L-1:0] lane_word_sync_i = '0, lane_marker_ok_i = '0;
  logic [L-1:0] lane_marker_wrong_i = '0, lane_marker_malformed_i = '0;
  logic [L-1:0] lane_bip_bad_i = '0;
  logic [7:0] lane_marker_id_i = 8'h1B, pkt_bytes_i = 8'h08;
  logic remote_fault_det_i = 1'b0, lf_seq_i = 1'b0, column_i = 1'b0;
  logic pkt_valid_i = 1'b0, pkt_sop_i = 1'b0, pkt_eop_i = 1'b0;
  logic [55:0] pkt_preamble_i = 56'hA1B2C3D4E5F607, preamble_o;
  logic [31:0] pkt_fcs_i = 32'h0, pkt_fcs_calc_i = 32'h12345678;
  logic aligned_err_o, misaligned_o, remote_fault_o, truncated_o;
  logic internal_local_fault_o, received_local_fault_o, local_fault_o;
  logic high_error_rate_flag_o, preamble_valid_o, pkt_drop_o;
  logic [L-1:0] marker_word_error_o, lane_synced_o, lane_demux_found_o;
  logic [L-1:0] bip_err_o;
  logic [7:0] lane_id_per_physical_lane_o;
  logic [1:0] bad_fcs_o, stomped_fcs_o;
  int mismatches = 0, comparisons = 0, k;
  int n_bad, n_stomp, n_trunc, n_mis, n_bip;
  // Rows: {aligned, ber, remote} then expected five status levels
  logic [7:0] rows [4] = '{8'h80, 8'h37, 8'hCB, 8'hA4};

  rsf_rx_status #(.L(L), .MF_CYCLES(MF)) dut_u (
    .mclk_i(mclk_i), .rst_n_i(rst_n_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
    .avs_writedata_i(avs_writedata_i), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o),
    .lane_word_sync_i(lane_word_sync_i), .lane_marker_ok_i(lane_marker_ok_i),
    .lane_marker_wrong_i(lane_marker_wrong_i),
    .lane_marker_malformed_i(lane_marker_malformed_i),
    .lane_marker_id_i(lane_marker_id_i), .lane_bip_bad_i(lane_bip_bad_i),
    .lanes_aligned_i(lanes_aligned_i), .ber_high_i(ber_high_i),
    .remote_fault_det_i(remote_fault_det_i), .lf_seq_i(lf_seq_i),
    .column_i(column_i), .pkt_valid_i(pkt_valid_i), .pkt_sop_i(pkt_sop_i),
    .pkt_eop_i(pkt_eop_i), .pkt_bytes_i(pkt_bytes_i),
    .pkt_preamble_i(pkt_preamble_i), .pkt_fcs_i(pkt_fcs_i),
    .pkt_fcs_calc_i(pkt_fcs_calc_i), .aligned_err_o(aligned_err_o),
    .misaligned_o(misaligned_o), .marker_word_error_o(marker_word_error_o),
    .remote_fault_o(remote_fault_o),
    .lane_id_per_physical_lane_o(lane_id_per_physical_lane_o),
    .lane_synced_o(lane_synced_o), .lane_demux_found_o(lane_demux_found_o),
    .bad_fcs_o(bad_fcs_o), .stomped_fcs_o(stomped_fcs_o),
    .truncated_o(truncated_o), .pkt_drop_o(pkt_drop_o),
    .internal_local_fault_o(internal_local_fault_o),
    .received_local_fault_o(received_local_fault_o),
    .local_fault_o(local_fault_o), .bip_err_o(bip_err_o),
    .high_error_rate_flag_o(high_error_rate_flag_o),
    .preamble_o(preamble_o), .preamble_valid_o(preamble_valid_o));

  rsf_user_model #(.L(L)) usr_u (
    .mclk_i(mclk_i), .bad_fcs_i(bad_fcs_o), .stomped_fcs_i(stomped_fcs_o),
    .truncated_i(truncated_o), .misaligned_i(misaligned_o),
    .bip_err_i(bip_err_o), .n_bad_o(n_bad), .n_stomp_o(n_stomp),
    .n_trunc_o(n_trunc), .n_mis_o(n_mis), .n_bip_o(n_bip));

  // ----------
  // Tasks
  // ----------
  task automatic tick(input int n);
    repeat (n) @(posedge mclk_i);
  endtask
  task automatic chk(input string nm, input logic [63:0] e, g);
    comparisons++;
    if (g !== e) begin
      mismatches++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Request holds until the edge that samples waitrequest low
  task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_write_i <= w;
    avs_read_i <= !w;
    do begin
      @(posedge mclk_i);
    end while (avs_waitrequest_o !== 1'b0);
    rd = avs_readdata_o;
    avs_read_i <= 1'b0;
    avs_write_i <= 1'b0;
    @(posedge mclk_i);
  endtask
  task automatic beat(input logic s, e, input logic [31:0] f);
    pkt_valid_i <= 1'b1;
    pkt_sop_i <= s;
    pkt_eop_i <= e;
    pkt_fcs_i <= f;
    @(posedge mclk_i);
  endtask
  task automatic end_of_test;
    if (mismatches == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  initial forever #10 mclk_i = ~mclk_i;
  initial begin
    repeat (5000) @(posedge mclk_i);
    mismatches++;
    end_of_test();
  end

  initial begin
    tick(8);
    rst_n_i <= 1'b1;
    tick(1);
    bus(1'b0, rsf_pkg::OFF_CTRL, 32'h0);
    chk("ctrl", 64'h4, rd);
    bus(1'b0, rsf_pkg::OFF_MAXLEN, 32'h0);
    chk("maxlen", 64'h2580, rd);
    bus(1'b0, 6'h10, 32'h0);
    chk("unmapped", 64'h0, rd);
    foreach (rows[i]) begin
      {lanes_aligned_i, ber_high_i, remote_fault_det_i} <= rows[i][7:5];
      tick(3);
      chk("levels", rows[i][4:0], {aligned_err_o, high_error_rate_flag_o,
          remote_fault_o, internal_local_fault_o, local_fault_o});
    end
    bus(1'b1, rsf_pkg::OFF_CTRL, 32'h2);
    tick(2);
    chk("test pattern", 64'h1, internal_local_fault_o);
    lf_seq_i <= 1'b1;
    beat(1'b1, 1'b1, pkt_fcs_calc_i);
    pkt_valid_i <= 1'b0;
    tick(4);
    lf_seq_i <= 1'b0;
    chk("pre off", 64'h0, preamble_o);
    chk("lf ignored", 64'h0, received_local_fault_o);
    bus(1'b1, rsf_pkg::OFF_CTRL, 32'h5);
    bus(1'b1, rsf_pkg::OFF_MAXLEN, 32'h10);
    beat(1'b1, 1'b1, ~pkt_fcs_calc_i);
    beat(1'b1, 1'b1, 32'h0);
    chk("pre valid", 64'h1, preamble_valid_o);
    chk("preamble", 64'hA1B2C3D4E5F607, preamble_o);
    beat(1'b1, 1'b0, 32'h0);
    beat(1'b0, 1'b0, 32'h0);
    beat(1'b0, 1'b0, 32'h0);
    beat(1'b0, 1'b1, pkt_fcs_calc_i);
    chk("drop", 64'h1, pkt_drop_o);
    pkt_valid_i <= 1'b0;
    lane_bip_bad_i <= 4'h1;
    lane_marker_malformed_i <= 4'h2;
    tick(1);
    lane_bip_bad_i <= 4'h3;
    tick(1);
    lane_bip_bad_i <= 4'h0;
    lane_marker_malformed_i <= 4'h0;
    lane_marker_wrong_i <= 4'h1;
    tick(1);
    lane_marker_wrong_i <= 4'h0;
    lane_word_sync_i <= 4'hF;
    tick(MF + 4);
    chk("bad count", 64'h1, n_bad);
    chk("stomp count", 64'h1, n_stomp);
    chk("trunc count", 64'h1, n_trunc);
    chk("parity count", 64'h3, n_bip);
    chk("early mis", 64'h0, n_mis);
    chk("synced early", 64'h0, lane_synced_o);
    lane_marker_ok_i <= 4'hF;
    tick(1);
    lane_marker_ok_i <= 4'h0;
    tick(2);
    chk("synced", 64'hF, lane_synced_o);
    chk("lane id", 64'h1B, lane_id_per_physical_lane_o);
    chk("demux", 64'hF, lane_demux_found_o);
    bus(1'b0, rsf_pkg::OFF_LANES, 32'h0);
    chk("lanes reg", 64'h000F000F, rd);
    lane_marker_wrong_i <= 4'h2;
    tick(1);
    lane_marker_wrong_i <= 4'h0;
    k = 0;
    do begin
      tick(1);
      k++;
    end while (misaligned_o !== 1'b1 && k < 40);
    chk("mis delay", MF + 1, k);
    lf_seq_i <= 1'b1;
    column_i <= 1'b1;
    tick(4);
    lf_seq_i <= 1'b0;
    k = 0;
    do begin
      tick(1);
      k++;
    end while (received_local_fault_o !== 1'b1 && k < 10);
    chk("rx fault", 64'h1, received_local_fault_o);
    bus(1'b0, rsf_pkg::OFF_STATUS, 32'h0);
    chk("status", 64'h5A, rd);
    tick(140);
    chk("rx fault gone", 64'h0, received_local_fault_o);
    lanes_aligned_i <= 1'b0;
    tick(2);
    rst_n_i <= 1'b0;
    tick(2);
    chk("in reset", 64'h0, {aligned_err_o, local_fault_o, remote_fault_o});
    rst_n_i <= 1'b1;
    tick(2);
    chk("after reset", 64'h1, aligned_err_o);
    end_of_test();
  end
endmodule // rx_path_status_flags_test
